// >>> logic/ssww_pkg.sv
// Package with timing constants and state type of the supervisor window watchdog
package ssww_pkg;
  // Internal oscillator rate in kHz
  localparam int unsigned CLK_KHZ = 40000;
  // Documented times
  localparam int unsigned RESET_DELAY_MS = 25;
  localparam int unsigned GLITCH_NS = 3000;
  localparam int unsigned WIN_SHORT_US = 250000;
  localparam int unsigned WIN_LONG_US = 2500000;
  localparam int unsigned LB_SHORT_WIDE_NS = 7860000;
  localparam int unsigned LB_SHORT_NARROW_NS = 2000000;
  localparam int unsigned LB_LONG_WIDE_NS = 78200000;
  localparam int unsigned LB_LONG_NARROW_NS = 19600000;
  // Derived cycle counts
  localparam int unsigned RESET_DELAY_CYC = RESET_DELAY_MS * CLK_KHZ;
  localparam int unsigned GLITCH_CYC = (GLITCH_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int unsigned WIN_SHORT_CYC = (WIN_SHORT_US / 1000) * CLK_KHZ;
  localparam int unsigned WIN_LONG_CYC = (WIN_LONG_US / 1000) * CLK_KHZ;
  localparam int unsigned LB_SHORT_WIDE_CYC = (LB_SHORT_WIDE_NS / 1000) * (CLK_KHZ / 1000);
  localparam int unsigned LB_SHORT_NARROW_CYC = (LB_SHORT_NARROW_NS / 1000) * (CLK_KHZ / 1000);
  localparam int unsigned LB_LONG_WIDE_CYC = (LB_LONG_WIDE_NS / 1000) * (CLK_KHZ / 1000);
  localparam int unsigned LB_LONG_NARROW_CYC = (LB_LONG_NARROW_NS / 1000) * (CLK_KHZ / 1000);
  // Counter width covers the longest window
  localparam int unsigned CNT_W = 27;
  localparam logic [CNT_W-1:0] CNT_ZERO = 27'h0000000;
  // Reset values
  localparam logic SYNC_RST_VAL = 1'b0;
  localparam logic SUPPLY_RST_VAL = 1'b0;

  typedef enum logic [1:0] {
    SSWW_HOLD,
    SSWW_DELAY,
    SSWW_ON
  } ssww_state_type;
endpackage : ssww_pkg

// >>> logic/ssww_glitch_filter.sv
// Glitch filter that confirms a supply-low indication after a minimum duration
`timescale 1ns/1ps
module ssww_glitch_filter #(
  parameter int unsigned FILTER_CYC = ssww_pkg::GLITCH_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Synchronised raw supply-low level
  input wire logic i_low_raw,
  // Confirmed supply-low level
  output logic o_low
);
  localparam int unsigned W = $clog2(FILTER_CYC + 1);
  localparam logic [W-1:0] LIMIT = W'(FILTER_CYC);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic low_r;
  logic low_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    low_nxt = low_r;
    if (!i_low_raw) begin
      // Low drops clear at once; the reset side applies the delay
      cnt_nxt = '0;
      low_nxt = 1'b0;
    end else if (cnt_r < LIMIT - W'(1)) begin
      cnt_nxt = cnt_r + W'(1);
    end else begin
      low_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      low_r <= ssww_pkg::SUPPLY_RST_VAL;
    end else begin
      cnt_r <= cnt_nxt;
      low_r <= low_nxt;
    end
  end

  assign o_low = low_r;
endmodule : ssww_glitch_filter

// >>> logic/ssww_watchdog.sv
// Supervisor with window watchdog driving an active-low processor reset
// Notes on behaviour
// - Supply low drives reset output low
// - Release after full delay; drop restarts
// - Ignore dips shorter than glitch filter
// - Timeout strap picks 0.25 s or 2.5 s
// - Ratio strap picks larger or smaller lower bound
// - Edge inside window avoids reset
// - Missing edge before upper bound faults
// - Early edge with bound active faults
// - First window after release has no lower bound
// - First edge enables lower bound checking
// - Accepted edge restarts window, clears timers
// - Three states: on drives reset high, hold and delay drive it low
// - Trigger edge seen in the cycle the synchroniser output rises
`timescale 1ns/1ps
module ssww_watchdog #(
  parameter int unsigned RESET_DELAY_CYC = ssww_pkg::RESET_DELAY_CYC,
  parameter int unsigned GLITCH_CYC = ssww_pkg::GLITCH_CYC,
  parameter int unsigned WIN_SHORT_CYC = ssww_pkg::WIN_SHORT_CYC,
  parameter int unsigned WIN_LONG_CYC = ssww_pkg::WIN_LONG_CYC,
  parameter int unsigned LB_SHORT_WIDE_CYC = ssww_pkg::LB_SHORT_WIDE_CYC,
  parameter int unsigned LB_SHORT_NARROW_CYC = ssww_pkg::LB_SHORT_NARROW_CYC,
  parameter int unsigned LB_LONG_WIDE_CYC = ssww_pkg::LB_LONG_WIDE_CYC,
  parameter int unsigned LB_LONG_NARROW_CYC = ssww_pkg::LB_LONG_NARROW_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Supply comparator, high while supply is beneath the trip threshold
  input wire logic i_supply_trip_threshold_low,
  // Straps and trigger pins
  input wire logic i_timeout_select_strap,
  input wire logic i_ratio_select_strap,
  input wire logic i_watchdog_trigger_in,
  // Processor reset, active low
  output logic o_reset_n,
  // Open-drain view of the reset pin
  output logic o_reset_oe,
  // Watchdog fault pulse, for observation
  output logic o_wdog_fault
);
  localparam int unsigned CW = ssww_pkg::CNT_W;

  // Pin synchronisers
  logic [1:0] trip_sync_r;
  logic [1:0] trip_sync_nxt;
  logic [1:0] trig_sync_r;
  logic [1:0] trig_sync_nxt;
  logic [1:0] strap_sync_r;
  logic [1:0] strap_sync_nxt;
  logic trig_prev_r;
  logic trig_prev_nxt;

  // Supervisor state
  ssww_pkg::ssww_state_type state_r;
  ssww_pkg::ssww_state_type state_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic lb_en_r;
  logic lb_en_nxt;
  logic reset_n_r;
  logic reset_n_nxt;
  logic fault_r;
  logic fault_nxt;

  logic supply_low;
  logic trig_rise;
  logic [CW-1:0] win_cyc;
  logic [CW-1:0] lb_cyc;

  // Strap decode; used for both bounds
  function automatic logic [CW-1:0] pick(input logic sel, input int unsigned a,
                                          input int unsigned b);
    pick = sel ? CW'(b) : CW'(a);
  endfunction : pick

  ssww_glitch_filter #(
    .FILTER_CYC(GLITCH_CYC)
  ) u_filter (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_low_raw(trip_sync_r[1]),
    .o_low(supply_low)
  );

  always_comb begin
    trip_sync_nxt = {trip_sync_r[0], i_supply_trip_threshold_low};
    trig_sync_nxt = {trig_sync_r[0], i_watchdog_trigger_in};
    strap_sync_nxt[0] = i_timeout_select_strap;
    strap_sync_nxt[1] = i_ratio_select_strap;
    trig_prev_nxt = trig_sync_r[1];
  end

  // Straps cross two stages, packed as one strap per index
  logic [1:0] strap_meta_r;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      trip_sync_r <= 2'h3;
      trig_sync_r <= 2'h0;
      strap_meta_r <= 2'h0;
      strap_sync_r <= 2'h0;
      trig_prev_r <= ssww_pkg::SYNC_RST_VAL;
    end else begin
      trip_sync_r <= trip_sync_nxt;
      trig_sync_r <= trig_sync_nxt;
      strap_meta_r <= strap_sync_nxt;
      strap_sync_r <= strap_meta_r;
      trig_prev_r <= trig_prev_nxt;
    end
  end

  // Edge seen in the same cycle the synchroniser output rises
  assign trig_rise = trig_sync_r[1] & ~trig_prev_r;

  // Upper bound from timeout strap
  assign win_cyc = pick(strap_sync_r[0], WIN_SHORT_CYC, WIN_LONG_CYC);
  // Lower bound: ratio strap low gives the larger value
  always_comb begin
    if (!strap_sync_r[0]) begin
      lb_cyc = pick(strap_sync_r[1], LB_SHORT_WIDE_CYC, LB_SHORT_NARROW_CYC);
    end else begin
      lb_cyc = pick(strap_sync_r[1], LB_LONG_WIDE_CYC, LB_LONG_NARROW_CYC);
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    lb_en_nxt = lb_en_r;
    reset_n_nxt = reset_n_r;
    fault_nxt = 1'b0;
    case (state_r)
      ssww_pkg::SSWW_HOLD: begin
        reset_n_nxt = 1'b0;
        cnt_nxt = ssww_pkg::CNT_ZERO;
        lb_en_nxt = 1'b0;
        if (!supply_low) begin
          state_nxt = ssww_pkg::SSWW_DELAY;
        end
      end
      ssww_pkg::SSWW_DELAY: begin
        reset_n_nxt = 1'b0;
        lb_en_nxt = 1'b0;
        if (supply_low) begin
          // Any dip confirmed by the glitch filter restarts the delay
          state_nxt = ssww_pkg::SSWW_HOLD;
          cnt_nxt = ssww_pkg::CNT_ZERO;
        end else if (cnt_r >= CW'(RESET_DELAY_CYC - 1)) begin
          state_nxt = ssww_pkg::SSWW_ON;
          reset_n_nxt = 1'b1;
          cnt_nxt = ssww_pkg::CNT_ZERO;
          lb_en_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      ssww_pkg::SSWW_ON: begin
        if (supply_low) begin
          state_nxt = ssww_pkg::SSWW_HOLD;
          reset_n_nxt = 1'b0;
          cnt_nxt = ssww_pkg::CNT_ZERO;
        end else if (trig_rise && lb_en_r && cnt_r < lb_cyc) begin
          // Early edge once lower bound is armed
          state_nxt = ssww_pkg::SSWW_DELAY;
          reset_n_nxt = 1'b0;
          fault_nxt = 1'b1;
          cnt_nxt = ssww_pkg::CNT_ZERO;
        end else if (trig_rise) begin
          // Accepted edge opens a new window
          cnt_nxt = ssww_pkg::CNT_ZERO;
          lb_en_nxt = 1'b1;
        end else if (cnt_r >= win_cyc - CW'(1)) begin
          state_nxt = ssww_pkg::SSWW_DELAY;
          reset_n_nxt = 1'b0;
          fault_nxt = 1'b1;
          cnt_nxt = ssww_pkg::CNT_ZERO;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      default: begin
        state_nxt = ssww_pkg::SSWW_HOLD;
        reset_n_nxt = 1'b0;
        cnt_nxt = ssww_pkg::CNT_ZERO;
        lb_en_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ssww_pkg::SSWW_HOLD;
      cnt_r <= ssww_pkg::CNT_ZERO;
      lb_en_r <= 1'b0;
      reset_n_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      lb_en_r <= lb_en_nxt;
      reset_n_r <= reset_n_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign o_reset_n = reset_n_r;
  // Pin is pulled low only; high comes from the external pull-up
  assign o_reset_oe = ~reset_n_r;
  assign o_wdog_fault = fault_r;
endmodule : ssww_watchdog

// >>> testbench/ssww_chk.sv
// Port checker for the supervisor window watchdog
`timescale 1ns/1ps
module ssww_chk #(
  parameter int unsigned RESET_DELAY_CYC = 50,
  parameter int unsigned WIN_LONG_CYC = 800
) (
  // Watched ports
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_supply_trip_threshold_low,
  input wire logic i_timeout_select_strap,
  input wire logic i_ratio_select_strap,
  input wire logic i_watchdog_trigger_in,
  input wire logic o_reset_n,
  input wire logic o_reset_oe,
  input wire logic o_wdog_fault
);
  logic [31:0] good_r;
  logic [31:0] idle_r;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Cycles of good supply, and cycles since the last trigger edge while running
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      good_r <= '0;
      idle_r <= '0;
    end else begin
      good_r <= i_supply_trip_threshold_low ? '0 : good_r + 1;
      idle_r <= (!o_reset_n || $rose(i_watchdog_trigger_in)) ? '0 : idle_r + 1;
    end
  end
  oe_tracks_a: assert property (o_reset_oe == !o_reset_n)
    else $error("reset enable disagrees");
  supply_low_a: assert property (i_supply_trip_threshold_low [*8] |-> ##[0:4] !o_reset_n)
    else $error("low supply left reset high");
  release_wait_a: assert property ($rose(o_reset_n) |-> good_r >= RESET_DELAY_CYC)
    else $error("reset released early");
  short_dip_a: assert property (o_reset_n && !i_supply_trip_threshold_low
    ##1 i_supply_trip_threshold_low [*2] ##1 !i_supply_trip_threshold_low |=> o_reset_n [*6])
    else $error("short dip caused reset");
  fault_resets_a: assert property (o_wdog_fault |-> ##[0:1] !o_reset_n)
    else $error("fault without reset");
  fault_pulse_a: assert property (o_wdog_fault |=> !o_wdog_fault)
    else $error("fault longer than one cycle");
  hold_after_a: assert property ($fell(o_reset_n) |=> !o_reset_n [*8])
    else $error("reset not held");
  upper_bound_a: assert property (idle_r <= WIN_LONG_CYC + 16)
    else $error("missing trigger not caught");
  cover property (o_wdog_fault);
  cover property ($rose(o_reset_n));
  cover property (i_ratio_select_strap && $rose(i_watchdog_trigger_in));
endmodule : ssww_chk

// >>> testbench/ssww_cpu_model.sv
// Processor model raising the trigger once every i_gap plus one cycles
`timescale 1ns/1ps
module ssww_cpu_model (
  // Clock and command
  input wire logic i_sys_clk,
  input wire logic i_en,
  input wire logic [15:0] i_gap,
  // Trigger toward the watchdog
  output logic o_trig
);
  logic [15:0] cnt_r = 16'h0000;
  initial o_trig = 1'b0;
  // Gap must exceed 8 so the pulse has a low phase
  always @(posedge i_sys_clk) begin
    cnt_r <= (i_en && cnt_r < i_gap) ? cnt_r + 16'h0001 : 16'h0000;
    o_trig <= i_en && cnt_r >= i_gap - 16'h0008;
  end
endmodule : ssww_cpu_model

// >>> testbench/tb_top.sv
// Testbench for the supervisor window watchdog
`timescale 1ns/1ps
module tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic sup = 1'b0;
  logic tsel = 1'b0;
  logic rsel = 1'b0;
  logic en = 1'b0;
  logic [15:0] gap = 16'h00C8;
  logic trig;
  logic rst_n;
  logic flt;
  logic oe;
  // Shortened timing so every scenario fits in a few thousand cycles
  localparam int DLY = 50;
  localparam int GLT = 4;
  localparam int WS = 400;
  localparam int WL = 800;
  localparam int LSW = 40;
  localparam int LSN = 10;
  localparam int LLW = 80;
  localparam int LLN = 20;
  int bad_count = 0;
  int n_compared = 0;
  int n_flt = 0;
  int n;
  int f;
  initial forever #12.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (flt === 1'b1) n_flt++;
  ssww_cpu_model cpu (.i_sys_clk(i_sys_clk), .i_en(en), .i_gap(gap), .o_trig(trig));
  ssww_watchdog #(.RESET_DELAY_CYC(DLY), .GLITCH_CYC(GLT), .WIN_SHORT_CYC(WS),
    .WIN_LONG_CYC(WL), .LB_SHORT_WIDE_CYC(LSW), .LB_SHORT_NARROW_CYC(LSN),
    .LB_LONG_WIDE_CYC(LLW), .LB_LONG_NARROW_CYC(LLN)) dut (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_supply_trip_threshold_low(sup), .i_timeout_select_strap(tsel),
    .i_ratio_select_strap(rsel), .i_watchdog_trigger_in(trig), .o_reset_n(rst_n),
    .o_reset_oe(oe), .o_wdog_fault(flt));
  task automatic results();
    if (bad_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic step(input int c);
    repeat (c) @(posedge i_sys_clk);
    #2;
  endtask : step
  // Bounded wait for the reset output to reach v; n holds the cycles taken
  task automatic wait_rn(input logic v, input int lim);
    n = 0;
    while (rst_n !== v && n < lim) begin
      step(1);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      results();
    end
  endtask : wait_rn
  task automatic s_supply();
    sup = 1'b1;
    step(2);
    sup = 1'b0;
    step(10);
    chk(rst_n, 1);
    sup = 1'b1;
    step(12);
    chk(rst_n, 0);
    chk(oe, 1);
    sup = 1'b0;
    step(30);
    sup = 1'b1;
    step(12);
    sup = 1'b0;
    wait_rn(1'b1, 200);
    chk(n >= DLY, 1);
  endtask : s_supply
  task automatic s_service();
    f = n_flt;
    step(1500);
    chk(n_flt - f, 0);
    rsel = 1'b1;
    gap = 16'h0014;
    step(600);
    chk(n_flt - f, 0);
    chk(rst_n, 1);
  endtask : s_service
  task automatic s_early();
    rsel = 1'b0;
    wait_rn(1'b0, 100);
    en = 1'b0;
    wait_rn(1'b1, 200);
    chk(n >= DLY, 1);
    en = 1'b1;
    step(18);
    chk(rst_n, 1);
    wait_rn(1'b0, 60);
    // Fault pulse is counted on the edge after reset falls
    step(1);
    chk(n_flt - f, 2);
  endtask : s_early
  task automatic s_timeout();
    int w;
    en = 1'b0;
    for (int t = 0; t < 2; t++) begin
      tsel = t[0];
      w = t ? WL : WS;
      wait_rn(1'b1, 200);
      wait_rn(1'b0, 1200);
      chk(n >= w - 5 && n <= w + 10, 1);
    end
  endtask : s_timeout
  // Long window: period of 50 passes the narrow bound and breaks the wide one
  task automatic s_long();
    rsel = 1'b1;
    gap = 16'h0031;
    en = 1'b1;
    wait_rn(1'b1, 200);
    f = n_flt;
    step(300);
    chk(n_flt - f, 0);
    chk(rst_n, 1);
    rsel = 1'b0;
    wait_rn(1'b0, 100);
    step(1);
    chk(n_flt - f, 1);
  endtask : s_long
  initial begin
    step(20);
    i_rst = 1'b0;
    wait_rn(1'b1, 200);
    chk(n >= DLY && n <= DLY + 30, 1);
    en = 1'b1;
    s_supply();
    s_service();
    s_early();
    s_timeout();
    s_long();
    results();
  end
endmodule : tb_top
bind ssww_watchdog ssww_chk #(.RESET_DELAY_CYC(RESET_DELAY_CYC),
  .WIN_LONG_CYC(WIN_LONG_CYC)) chk_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_supply_trip_threshold_low(i_supply_trip_threshold_low),
  .i_timeout_select_strap(i_timeout_select_strap),
  .i_ratio_select_strap(i_ratio_select_strap),
  .i_watchdog_trigger_in(i_watchdog_trigger_in), .o_reset_n(o_reset_n),
  .o_reset_oe(o_reset_oe), .o_wdog_fault(o_wdog_fault));
